/* File: design/liu_channel_line_config.sv */
// Register bank and decode of per-channel line, termination and jitter settings
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
//
// Overview of operation
// - Codes 1c/1d select E1 HDB3, coax/TP120
// - Codes 08-0c T1 B8ZS pulses; 0d arbitrary
// - Impedance field: 100, 110, 75, 120 ohm
// - Jitter path: off, transmit, receive, receive
// - Jitter attenuator disabled after reset
// - Termination bits: zero means high impedance
module liu_channel_line_config #(
	parameter int NCH = liu_line_config_pkg::NUM_CHANNELS
) (
	input  wire logic                                i_ref_clk,
	input  wire logic                                i_rst_b,
	input  wire logic [liu_line_config_pkg::ADDR_W-1:0] i_awaddr,
	input  wire logic                                i_awvalid,
	output logic                                     o_awready,
	input  wire logic [31:0]                         i_wdata,
	input  wire logic [3:0]                          i_wstrb,
	input  wire logic                                i_wvalid,
	output logic                                     o_wready,
	output logic [1:0]                               o_bresp,
	output logic                                     o_bvalid,
	input  wire logic                                i_bready,
	input  wire logic [liu_line_config_pkg::ADDR_W-1:0] i_araddr,
	input  wire logic                                i_arvalid,
	output logic                                     o_arready,
	output logic [31:0]                              o_rdata,
	output logic [1:0]                               o_rresp,
	output logic                                     o_rvalid,
	input  wire logic                                i_rready,
	output liu_line_config_pkg::chan_cfg_s [NCH-1:0] o_chan_cfg,
	output liu_line_config_pkg::ja_global_s          o_ja_global
);
	import liu_line_config_pkg::*;

	typedef struct packed {
		logic [NCH-1:0][7:0] eq_ctrl;
		logic [NCH-1:0][7:0] term_ja;
		logic                ja_bw;
		logic                fifo_sel;
		logic                aw_held;
		logic [ADDR_W-1:0]   aw_addr;
		logic                w_held;
		logic [31:0]         w_data;
		logic                w_lane0;
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
		chan_cfg_s [NCH-1:0] cfg;
		ja_global_s          jag;
	} state_s;

	state_s st;
	state_s next_st;

	// Address decode result for one byte address
	typedef struct packed {
		logic       hit;
		logic       glb;
		logic       term;
		logic [2:0] ch;
	} dec_s;

	function automatic dec_s decode(input logic [ADDR_W-1:0] a);
		logic [7:0] idx;
		dec_s d;
		idx = a[9:2];
		d = '0;
		d.ch = idx[6:4];
		if (a[1:0] == 2'b00 && a[ADDR_W-1:10] == '0) begin
			if (idx == IDX_GLOBAL) begin
				d.hit = 1'b1;
				d.glb = 1'b1;
			end else if (idx < CHAN_STRIDE_IDX * 8'(NCH) && idx[3:0] == IDX_EQ_CTRL[3:0]) begin
				d.hit = 1'b1;
			end else if (idx < CHAN_STRIDE_IDX * 8'(NCH) && idx[3:0] == IDX_TERM_JA[3:0]) begin
				d.hit = 1'b1;
				d.term = 1'b1;
			end
		end
		return d;
	endfunction

	// Cable length code and termination byte decode for one channel
	function automatic chan_cfg_s decode_chan(input logic [7:0] eq, input logic [7:0] tj);
		chan_cfg_s c;
		logic [4:0] code;
		code = eq[4:0];
		c = '0;
		if (code >= CODE_T1_FIRST && code <= CODE_T1_ARB) begin
			c.mode = MODE_T1;
			c.coding = CODING_B8ZS;
			c.cable = CABLE_TP100;
			c.pulse_setting = 3'(code - CODE_T1_FIRST);
			c.arb_pulse = (code == CODE_T1_ARB);
		end else if (code == CODE_E1_COAX || code == CODE_E1_TP) begin
			c.mode = MODE_E1;
			c.coding = CODING_HDB3;
			c.cable = (code == CODE_E1_COAX) ? CABLE_COAX75 : CABLE_TP120;
		end
		c.impedance = impedance_e'(tj[POS_IMP+:2]);
		case (tj[POS_JA_PATH+:2])
			2'b00: c.ja_path = JA_OFF;
			2'b01: c.ja_path = JA_TX;
			default: c.ja_path = JA_RX;
		endcase
		c.rx_term_on = tj[POS_RX_TERM];
		c.tx_term_on = tj[POS_TX_TERM];
		return c;
	endfunction

	// Bus handshakes, register writes, read data and decoded outputs
	always_comb begin
		dec_s wd;
		dec_s rd;
		wd = decode(st.aw_addr);
		rd = decode(i_araddr);
		next_st = st;
		next_st.awready = 1'b0;
		next_st.wready = 1'b0;
		next_st.arready = 1'b0;
		if (i_awvalid && !st.aw_held && !st.bvalid && !st.awready) begin
			next_st.awready = 1'b1;
			next_st.aw_held = 1'b1;
			next_st.aw_addr = i_awaddr;
		end
		if (i_wvalid && !st.w_held && !st.bvalid && !st.wready) begin
			next_st.wready = 1'b1;
			next_st.w_held = 1'b1;
			next_st.w_data = i_wdata;
			next_st.w_lane0 = i_wstrb[0];
		end
		if (st.aw_held && st.w_held && !st.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = wd.hit ? RESP_OKAY : RESP_SLVERR;
			if (wd.hit && st.w_lane0) begin
				if (wd.glb) begin
					next_st.ja_bw = st.w_data[POS_JA_BW];
					next_st.fifo_sel = st.w_data[POS_FIFO];
				end else if (wd.term) begin
					next_st.term_ja[wd.ch] = st.w_data[7:0];
					next_st.term_ja[wd.ch][POS_JA_BW] = 1'b0;
					next_st.term_ja[wd.ch][POS_FIFO] = 1'b0;
					next_st.ja_bw = st.w_data[POS_JA_BW];               // Global via any channel
					next_st.fifo_sel = st.w_data[POS_FIFO];
				end else begin
					next_st.eq_ctrl[wd.ch] = {3'h0, st.w_data[4:0]};
				end
			end
		end else if (st.bvalid && i_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.rvalid && i_rready) begin
			next_st.rvalid = 1'b0;
		end else if (i_arvalid && !st.rvalid && !st.arready) begin
			next_st.arready = 1'b1;
			next_st.rvalid = 1'b1;
			next_st.rresp = rd.hit ? RESP_OKAY : RESP_SLVERR;
			next_st.rdata = 32'h0000_0000;
			if (rd.hit && rd.glb) begin
				next_st.rdata[POS_JA_BW] = st.ja_bw;
				next_st.rdata[POS_FIFO] = st.fifo_sel;
			end else if (rd.hit && rd.term) begin
				next_st.rdata[7:0] = st.term_ja[rd.ch];
				next_st.rdata[POS_JA_BW] = st.ja_bw;                    // Global bits mirrored
				next_st.rdata[POS_FIFO] = st.fifo_sel;
			end else if (rd.hit) begin
				next_st.rdata[7:0] = st.eq_ctrl[rd.ch];
			end
		end
		for (int i = 0; i < NCH; i++) begin
			next_st.cfg[i] = decode_chan(next_st.eq_ctrl[i], next_st.term_ja[i]);
		end
		next_st.jag.ja_bw_wide = next_st.ja_bw;
		next_st.jag.fifo_64 = next_st.fifo_sel;
		next_st.jag.fifo_delay = next_st.fifo_sel ? 6'h20 : 6'h10;
	end

	// State register; reset leaves terminations high-Z and jitter off
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= '0;
			st.jag.fifo_delay <= 6'h10;
		end else begin
			st <= next_st;
		end
	end

	assign o_awready = st.awready;
	assign o_wready = st.wready;
	assign o_bvalid = st.bvalid;
	assign o_bresp = st.bresp;
	assign o_arready = st.arready;
	assign o_rvalid = st.rvalid;
	assign o_rdata = st.rdata;
	assign o_rresp = st.rresp;
	assign o_chan_cfg = st.cfg;
	assign o_ja_global = st.jag;

	property p_e1_decode;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		st.eq_ctrl[0][4:0] == CODE_E1_COAX |=> o_chan_cfg[0].mode == MODE_E1
			|| $past(st.eq_ctrl[0][4:0]) != st.eq_ctrl[0][4:0];
	endproperty
	a_e1_decode: assert property (p_e1_decode) else $error("E1 coax code not decoded");

	property p_t1_decode;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_chan_cfg[0].mode == MODE_T1 |-> o_chan_cfg[0].coding == CODING_B8ZS
			&& o_chan_cfg[0].cable == CABLE_TP100 && o_chan_cfg[0].pulse_setting <= 3'd5;
	endproperty
	a_t1_decode: assert property (p_t1_decode) else $error("T1 decode inconsistent");

	property p_imp;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_chan_cfg[NCH-1].impedance == impedance_e'(st.term_ja[NCH-1][POS_IMP+:2]);
	endproperty
	a_imp: assert property (p_imp) else $error("Impedance field mismatch");

	property p_ja_path;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		st.term_ja[NCH-1][POS_JA_PATH+1] |-> o_chan_cfg[NCH-1].ja_path == JA_RX;
	endproperty
	a_ja_path: assert property (p_ja_path) else $error("Jitter path not receive");

	property p_reset_ja;
		@(posedge i_ref_clk) $rose(i_rst_b) |-> o_chan_cfg[0].ja_path == JA_OFF;
	endproperty
	a_reset_ja: assert property (p_reset_ja) else $error("Jitter on after reset");

	property p_term;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_chan_cfg[NCH-1].rx_term_on == st.term_ja[NCH-1][POS_RX_TERM]
			&& o_chan_cfg[NCH-1].tx_term_on == st.term_ja[NCH-1][POS_TX_TERM];
	endproperty
	a_term: assert property (p_term) else $error("Termination select mismatch");

	property p_fifo_delay;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_ja_global.fifo_delay == (o_ja_global.fifo_64 ? 6'h20 : 6'h10);
	endproperty
	a_fifo_delay: assert property (p_fifo_delay) else $error("FIFO delay not half depth");

	property p_bresp_after;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
	endproperty
	a_bresp_after: assert property (p_bresp_after) else $error("Write response dropped"); // Bus hold

	c_write: cover property (@(posedge i_ref_clk) o_bvalid && i_bready);
	c_read: cover property (@(posedge i_ref_clk) o_rvalid && i_rready);
	c_e1: cover property (@(posedge i_ref_clk) o_chan_cfg[0].mode == MODE_E1);
endmodule

/* File: design/liu_line_config_pkg.sv */
// Package: offsets, field positions, reset values and decode types for line configuration
package liu_line_config_pkg;
	localparam int          NUM_CHANNELS      = 8;
	// Register indices are printed as word indices, so byte address = 4 * index
	localparam logic [7:0]  IDX_EQ_CTRL       = 8'h00;
	localparam logic [7:0]  IDX_TERM_JA       = 8'h01;
	localparam logic [7:0]  CHAN_STRIDE_IDX   = 8'h10;
	localparam logic [7:0]  IDX_GLOBAL        = 8'h80;
	localparam int          ADDR_W            = 12;
	localparam logic [7:0]  RESET_EQ_CTRL     = 8'h00;
	localparam logic [7:0]  RESET_TERM_JA     = 8'h00;
	// Field positions in the termination / jitter register
	localparam int          POS_RX_TERM       = 7;
	localparam int          POS_TX_TERM       = 6;
	localparam int          POS_IMP           = 4;
	localparam int          POS_JA_PATH       = 2;
	localparam int          POS_JA_BW         = 1;
	localparam int          POS_FIFO          = 0;
	// Cable length codes
	localparam logic [4:0]  CODE_T1_FIRST     = 5'h08;
	localparam logic [4:0]  CODE_T1_LAST      = 5'h0c;
	localparam logic [4:0]  CODE_T1_ARB       = 5'h0d;
	localparam logic [4:0]  CODE_E1_COAX      = 5'h1c;
	localparam logic [4:0]  CODE_E1_TP        = 5'h1d;
	localparam logic [1:0]  RESP_OKAY         = 2'b00;
	localparam logic [1:0]  RESP_SLVERR       = 2'b10;

	typedef enum logic [1:0] {MODE_NONE, MODE_T1, MODE_E1} line_mode_e;
	typedef enum logic [1:0] {CODING_NONE, CODING_B8ZS, CODING_HDB3} coding_e;
	typedef enum logic [1:0] {CABLE_NONE, CABLE_TP100, CABLE_COAX75, CABLE_TP120} cable_e;
	typedef enum logic [1:0] {IMP_100, IMP_110, IMP_75, IMP_120} impedance_e;
	typedef enum logic [1:0] {JA_OFF, JA_TX, JA_RX} ja_path_e;

	// Decoded per-channel line setup
	typedef struct packed {
		line_mode_e mode;
		coding_e    coding;
		cable_e     cable;
		logic [2:0] pulse_setting;
		logic       arb_pulse;
		impedance_e impedance;
		ja_path_e   ja_path;
		logic       rx_term_on;
		logic       tx_term_on;
	} chan_cfg_s;

	// Global jitter attenuator setup
	typedef struct packed {
		logic       ja_bw_wide;
		logic       fifo_64;
		logic [5:0] fifo_delay;
	} ja_global_s;
endpackage

/* File: verif/host_bus_master.sv */
// Host model issuing register writes and reads on the bus
`timescale 1ns/100ps
module host_bus_master (
	input  wire logic        i_clk,
	output logic [11:0]      o_awaddr,
	output logic             o_awvalid,
	input  wire logic        i_awready,
	output logic [31:0]      o_wdata,
	output logic [3:0]       o_wstrb,
	output logic             o_wvalid,
	input  wire logic        i_wready,
	input  wire logic [1:0]  i_bresp,
	input  wire logic        i_bvalid,
	output logic             o_bready,
	output logic [11:0]      o_araddr,
	output logic             o_arvalid,
	input  wire logic        i_arready,
	input  wire logic [31:0] i_rdata,
	input  wire logic [1:0]  i_rresp,
	input  wire logic        i_rvalid,
	output logic             o_rready
);
	// Idle bus at time zero
	initial begin
		{o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
		{o_awaddr, o_araddr, o_wdata, o_wstrb} = 60'h0;
	end
	// Write one word; each channel held until its own handshake edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		r = 2'h3;
		@(posedge i_clk);
		{o_awaddr, o_wdata, o_wstrb, o_awvalid, o_wvalid, o_bready} <= {a, d, 4'hf, 3'h7};
		do begin
			@(posedge i_clk);
			n++;
			if (o_awvalid && i_awready) begin
				{o_awvalid, o_awaddr} <= {1'b0, ~a}; // Released lines do not keep value
			end
			if (o_wvalid && i_wready) begin
				{o_wvalid, o_wdata} <= {1'b0, ~d};
			end
			if (o_bready && i_bvalid) begin
				o_bready <= 1'b0;
				r = i_bresp;
			end
			if (n > 64) tb.hang();
		end while (o_awvalid | o_wvalid | o_bready);
	endtask
	// Read one word; address held until taken, rready until data seen
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge i_clk);
		{o_araddr, o_arvalid, o_rready} <= {a, 2'h3};
		do begin
			@(posedge i_clk);
			n++;
			if (o_arvalid && i_arready) begin
				{o_arvalid, o_araddr} <= {1'b0, ~a};
			end
			if (o_rready && i_rvalid) begin
				o_rready <= 1'b0;
				{d, r} = {i_rdata, i_rresp};
			end
			if (n > 64) tb.hang();
		end while (o_arvalid | o_rready);
	endtask
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the line configuration register bank
`timescale 1ns/100ps
module tb;
	import liu_line_config_pkg::*;
	typedef struct packed {
		logic [4:0] code;
		line_mode_e mode;
		coding_e    coding;
		cable_e     cable;
		logic [2:0] pulse;
		logic       arb;
	} row_s;
	logic              i_ref_clk;
	logic              i_rst_b;
	logic [11:0]       awaddr, araddr;
	logic [31:0]       wdata, rdata, rdat, wd;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, resp;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	chan_cfg_s [7:0]   cfg;
	chan_cfg_s         exp;
	ja_global_s        jag;
	ja_path_e          ja;
	int                n_mismatch = 0;
	int                checks = 0;
	row_s              rows [11] = '{
		'{5'h08, MODE_T1, CODING_B8ZS, CABLE_TP100, 3'h0, 1'b0},
		'{5'h09, MODE_T1, CODING_B8ZS, CABLE_TP100, 3'h1, 1'b0},
		'{5'h0a, MODE_T1, CODING_B8ZS, CABLE_TP100, 3'h2, 1'b0},
		'{5'h0b, MODE_T1, CODING_B8ZS, CABLE_TP100, 3'h3, 1'b0},
		'{5'h0c, MODE_T1, CODING_B8ZS, CABLE_TP100, 3'h4, 1'b0},
		'{5'h0d, MODE_T1, CODING_B8ZS, CABLE_TP100, 3'h5, 1'b1},
		'{5'h1c, MODE_E1, CODING_HDB3, CABLE_COAX75, 3'h0, 1'b0},
		'{5'h1d, MODE_E1, CODING_HDB3, CABLE_TP120, 3'h0, 1'b0},
		'{5'h0e, MODE_NONE, CODING_NONE, CABLE_NONE, 3'h0, 1'b0},
		'{5'h07, MODE_NONE, CODING_NONE, CABLE_NONE, 3'h0, 1'b0},
		'{5'h08, MODE_T1, CODING_B8ZS, CABLE_TP100, 3'h0, 1'b0}};

	liu_channel_line_config u_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
		.o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .o_chan_cfg(cfg), .o_ja_global(jag));
	host_bus_master u_host (.i_clk(i_ref_clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
		.i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
		.i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
		.o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
		.i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready));

	// Compare one value and count it
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Final report and end of run
	task print_verdict;
		if (n_mismatch == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// A wait ran out of cycles
	task hang;
		n_mismatch++;
		print_verdict();
	endtask

	// Clock of 4 ns
	initial begin
		i_ref_clk = 1'b0;
		forever #2 i_ref_clk = ~i_ref_clk;
	end
	// Main sequence
	initial begin
		i_rst_b = 1'b0;
		repeat (16) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		@(posedge i_ref_clk);
		chk("cfg_rst", 32'h0, 32'(cfg[7]));
		chk("jag_rst", {24'h0, 2'b00, 6'd16}, 32'(jag));
		u_host.rd(12'h0c4, rdat, resp);
		chk("term_rst", 32'h0, rdat);
		// Cable code table on channel 0
		foreach (rows[i]) begin
			u_host.wr(12'h000, 32'(rows[i].code), resp);
			chk("code_resp", 32'(RESP_OKAY), 32'(resp));
			exp = '{rows[i].mode, rows[i].coding, rows[i].cable, rows[i].pulse, rows[i].arb,
				IMP_100, JA_OFF, 1'b0, 1'b0};
			chk("cfg0", 32'(exp), 32'(cfg[0]));
		end
		// Every impedance and jitter path on the last channel
		for (int i = 0; i < 4; i++) begin
			wd = {24'h0, 1'b1, i[0], i[1:0], i[1:0], 2'b00};
			ja = (i > 1) ? JA_RX : ja_path_e'(i[1:0]);
			u_host.wr(12'h1c4, wd, resp);
			chk("cfg7", 32'({impedance_e'(i[1:0]), ja, 1'b1, i[0]}), 32'(cfg[7][5:0]));
			u_host.rd(12'h1c4, rdat, resp);
			chk("term_rd", wd, rdat);
		end
		// Global FIFO depth and bandwidth, mirrored in channel register
		u_host.wr(12'h200, 32'h3, resp);
		chk("jag_64", {24'h0, 2'b11, 6'd32}, 32'(jag));
		u_host.rd(12'h1c4, rdat, resp);
		chk("term_mirror", wd | 32'h3, rdat);
		u_host.wr(12'h200, 32'h0, resp);
		chk("jag_32", {24'h0, 2'b00, 6'd16}, 32'(jag));
		// Global bits written through one channel, seen through another
		u_host.wr(12'h084, 32'h1, resp);
		chk("jag_via_term", {24'h0, 2'b01, 6'd32}, 32'(jag));
		u_host.rd(12'h144, rdat, resp);
		chk("mirror_ch5", 32'h1, rdat);
		// Unmapped place is refused
		u_host.wr(12'hffc, 32'hff, resp);
		chk("bresp_bad", 32'(RESP_SLVERR), 32'(resp));
		u_host.rd(12'hffc, rdat, resp);
		chk("rresp_bad", 32'(RESP_SLVERR), 32'(resp));
		chk("rdata_bad", 32'h0, rdat);
		// Misaligned place is refused and writes nothing
		u_host.wr(12'h002, 32'h1c, resp);
		chk("bresp_misal", 32'(RESP_SLVERR), 32'(resp));
		chk("cfg0_kept", 32'(MODE_T1), 32'(cfg[0].mode));
		// Second reset in mid-run
		i_rst_b <= 1'b0;
		@(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		@(posedge i_ref_clk);
		chk("cfg7_rst2", 32'h0, 32'(cfg[7]));
		chk("cfg0_rst2", 32'h0, 32'(cfg[0]));
		chk("jag_rst2", {24'h0, 2'b00, 6'd16}, 32'(jag));
		u_host.rd(12'h1c4, rdat, resp);
		chk("term_rst2", 32'h0, rdat);
		print_verdict();
	end
endmodule
